/* shared/io_word_consts.svh */
// command field positions, keys, tags and reset values for the word decoder
`ifndef IO_WORD_CONSTS_SVH
`define IO_WORD_CONSTS_SVH

// command word layout
`define CMD_KIND_BIT 15
`define REG_ADDR_HI 14
`define REG_ADDR_LO 11
`define RST_KEY_HI 10
`define PIN_FIELD_HI 7
`define CHAN_HI 14
`define CHAN_LO 12
`define CODE_HI 11

// register addresses carried in bits 14:11
`define TS_REG_ADDR 4'hD
`define RST_REG_ADDR 4'hF

// software reset key, binary 10110101100
`define RST_KEY 11'h5AC

// readback tags
`define TEMP_TAG 4'h8
`define ADC_MSB 1'h0
`define RDBK_MSB 1'h1

// reset values
`define TS_RESET 8'h00
`define CODE_RESET 12'h000
`define WORD_RESET 16'h0000

`endif

/* shared/io_word_pkg.sv */
// types used by the command word decoder for decode, code writes and answers
package io_word_pkg;

	// kind of an incoming command word, one-hot
	typedef enum logic [4:0] {
		CMD_NONE = 5'h01,
		CMD_TS = 5'h02,
		CMD_RST = 5'h04,
		CMD_DAC = 5'h08,
		CMD_OTHER = 5'h10
	} cmd_kind_e;

	// converter data write fields
	typedef struct packed {
		logic [2:0] chan;
		logic [11:0] code;
	} code_wr_s;

	// layout of every returned word
	typedef struct packed {
		logic msb;
		logic [2:0] chan;
		logic [11:0] data;
	} rsp_s;

endpackage

/* rtl/dac_code_bank.sv */
// bank of stored output codes, one per channel, with read port
`include "io_word_consts.svh"
module dac_code_bank #(
	parameter int CHANNELS = 8,
	parameter int WIDTH = 12,
	parameter int CW = $clog2(CHANNELS)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic wr_en,
	input wire logic [CW-1:0] wr_chan,
	input wire logic [WIDTH-1:0] wr_code,
	input wire logic [CW-1:0] rd_chan,
	output logic [WIDTH-1:0] rd_code,
	output logic [CHANNELS*WIDTH-1:0] codes
);

	// ************************************************************
	// code storage
	// ************************************************************
	logic [WIDTH-1:0] code_q [CHANNELS]; // one code per channel
	logic [WIDTH-1:0] code_d [CHANNELS];

	// next codes: clear beats write so a reset word wins
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			code_d[i] = code_q[i];
			if (clr) begin
				code_d[i] = WIDTH'(`CODE_RESET);
			end else if (wr_en && (wr_chan == CW'(i))) begin
				code_d[i] = wr_code;
			end
		end
	end

	// register the codes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				code_q[i] <= WIDTH'(`CODE_RESET);
			end
		end else begin
			code_q <= code_d;
		end
	end

	// read port shows the stored value, so a same-cycle write reads old data
	always_comb begin
		rd_code = code_q[rd_chan];
		for (int i = 0; i < CHANNELS; i++) begin
			codes[i*WIDTH +: WIDTH] = code_q[i];
		end
	end

endmodule

/* rtl/io_word_decode.sv */
// command word decoder and readback word builder of the converter device
// Behaviour
// - address 1101 selects the three-state register
// - three-state bit n floats pin n, resets zero
// - address 1111 selects software reset register
// - exact key in bits 10:0 resets everything
// - bits 14:12 channel, bits 11:0 code stored
// - conversion word: bit15 low, channel, result
// - temperature word: tag 1000, then result
// - code readback: bit15 high, channel, code
`include "io_word_consts.svh"
module io_word_decode #(
	parameter int CHANNELS = 8,
	parameter int WIDTH = 12
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic CMD_VALID, // one word from the link layer
	input wire logic [15:0] CMD_WORD,
	input wire logic ADC_VALID, // conversion finished
	input wire logic [2:0] ADC_CHAN,
	input wire logic [WIDTH-1:0] ADC_DATA,
	input wire logic TEMP_VALID, // temperature conversion finished
	input wire logic [WIDTH-1:0] TEMP_DATA,
	input wire logic RDBK_REQ, // read back one stored code
	input wire logic [2:0] RDBK_CHAN,
	output logic [7:0] PIN_FLOAT,
	output logic [CHANNELS*WIDTH-1:0] DAC_CODES,
	output logic RSP_VALID,
	output logic [15:0] RSP_WORD,
	output logic SOFT_RST
);

	// ************************************************************
	// command decode
	// ************************************************************
	io_word_pkg::cmd_kind_e kind; // what the incoming word is
	io_word_pkg::code_wr_s code_wr; // write fields
	logic sw_clr; // key matched: clear the whole block
	logic [WIDTH-1:0] rd_code; // stored code of RDBK_CHAN

	// classify the word; bit 15 alone picks a data write
	always_comb begin
		code_wr = io_word_pkg::code_wr_s'(CMD_WORD[`CHAN_HI:0]);
		if (!CMD_VALID) begin
			kind = io_word_pkg::CMD_NONE;
		end else if (CMD_WORD[`CMD_KIND_BIT]) begin
			kind = io_word_pkg::CMD_DAC;
		end else if (CMD_WORD[`REG_ADDR_HI:`REG_ADDR_LO] == `TS_REG_ADDR) begin
			kind = io_word_pkg::CMD_TS;
		end else if (CMD_WORD[`REG_ADDR_HI:`REG_ADDR_LO] == `RST_REG_ADDR) begin
			kind = io_word_pkg::CMD_RST;
		end else begin
			kind = io_word_pkg::CMD_OTHER; // other registers live elsewhere
		end
	end

	// only the exact key resets; any other value is dropped
	assign sw_clr = (kind == io_word_pkg::CMD_RST)
		&& (CMD_WORD[`RST_KEY_HI:0] == `RST_KEY);

	// ************************************************************
	// three-state select register
	// ************************************************************
	logic [7:0] ts_q; // one float bit per pin
	logic [7:0] ts_d;

	// bits 10:8 are reserved and not stored, so junk there is harmless
	always_comb begin
		ts_d = ts_q;
		if (sw_clr) begin
			ts_d = `TS_RESET;
		end else if (kind == io_word_pkg::CMD_TS) begin
			ts_d = CMD_WORD[`PIN_FIELD_HI:0];
		end
	end

	// register the float bits
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ts_q <= `TS_RESET;
		end else begin
			ts_q <= ts_d;
		end
	end

	assign PIN_FLOAT = ts_q;

	// ************************************************************
	// output code storage
	// ************************************************************
	dac_code_bank #(
		.CHANNELS(CHANNELS),
		.WIDTH(WIDTH)
	) u_bank (
		.clk(CORE_CLK),
		.nrst(NRST),
		.clr(sw_clr),
		.wr_en(kind == io_word_pkg::CMD_DAC),
		.wr_chan(code_wr.chan),
		.wr_code(code_wr.code),
		.rd_chan(RDBK_CHAN),
		.rd_code(rd_code),
		.codes(DAC_CODES)
	);

	// ************************************************************
	// readback word builder
	// ************************************************************
	io_word_pkg::rsp_s rsp_q; // last word built
	io_word_pkg::rsp_s rsp_d;
	logic rsp_vld_q; // one-cycle strobe
	logic rsp_vld_d;
	logic srst_q; // reset pulse for the rest of the device
	logic srst_d;

	// one word per cycle: readback before conversion before temperature;
	// a losing source is dropped, the link layer must not overlap them
	always_comb begin
		rsp_d = rsp_q;
		rsp_vld_d = 1'b0;
		srst_d = sw_clr;
		if (sw_clr) begin
			rsp_d = io_word_pkg::rsp_s'(`WORD_RESET);
		end else if (RDBK_REQ) begin
			rsp_d = {`RDBK_MSB, RDBK_CHAN, rd_code};
			rsp_vld_d = 1'b1;
		end else if (ADC_VALID) begin
			rsp_d = {`ADC_MSB, ADC_CHAN, ADC_DATA};
			rsp_vld_d = 1'b1;
		end else if (TEMP_VALID) begin
			rsp_d = {`TEMP_TAG, TEMP_DATA};
			rsp_vld_d = 1'b1;
		end
	end

	// register the answer
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rsp_q <= io_word_pkg::rsp_s'(`WORD_RESET);
			rsp_vld_q <= 1'b0;
			srst_q <= 1'b0;
		end else begin
			rsp_q <= rsp_d;
			rsp_vld_q <= rsp_vld_d;
			srst_q <= srst_d;
		end
	end

	assign RSP_WORD = rsp_q;
	assign RSP_VALID = rsp_vld_q;
	assign SOFT_RST = srst_q;

	// ************************************************************
	// checks
	// ************************************************************
	chk_ts_select: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(CMD_VALID && !CMD_WORD[15] && CMD_WORD[14:11] == 4'hD)
		|=> PIN_FLOAT == $past(CMD_WORD[7:0]))
		else $error("float bits not loaded");

	chk_ts_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!(CMD_VALID && !CMD_WORD[15] && CMD_WORD[14:11] inside {4'hD, 4'hF})
		|=> $stable(PIN_FLOAT))
		else $error("float bits changed without a select word");

	chk_reset_key: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(CMD_VALID && CMD_WORD == 16'h7DAC)
		|=> SOFT_RST && PIN_FLOAT == 8'h00 && !RSP_VALID && DAC_CODES == '0)
		else $error("keyed reset did not clear state");

	chk_bad_key: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(CMD_VALID && CMD_WORD[15:11] == 5'h0F && CMD_WORD[10:0] != 11'h5AC)
		|=> !SOFT_RST && $stable(PIN_FLOAT) && $stable(DAC_CODES))
		else $error("wrong key disturbed state");

	chk_ctrl_no_code: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(CMD_VALID && !CMD_WORD[15] && CMD_WORD[14:11] != 4'hF)
		|=> $stable(DAC_CODES))
		else $error("control word changed a stored code");

	chk_code_store: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(CMD_VALID && CMD_WORD[15])
		|=> DAC_CODES[$past(CMD_WORD[14:12])*12 +: 12] == $past(CMD_WORD[11:0]))
		else $error("data write not stored");

	chk_rdbk_word: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(CMD_VALID && CMD_WORD[15]) ##1 (RDBK_REQ && !sw_clr
		&& RDBK_CHAN == $past(CMD_WORD[14:12]))
		|=> RSP_VALID && RSP_WORD == {1'b1, $past(RDBK_CHAN), $past(CMD_WORD[11:0], 2)})
		else $error("readback word wrong");

	chk_adc_word: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(ADC_VALID && !RDBK_REQ && !sw_clr)
		|=> RSP_VALID && !RSP_WORD[15] && RSP_WORD[14:12] == $past(ADC_CHAN)
		&& RSP_WORD[11:0] == $past(ADC_DATA))
		else $error("conversion word wrong");

	chk_temp_word: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(TEMP_VALID && !ADC_VALID && !RDBK_REQ && !sw_clr)
		|=> RSP_VALID && RSP_WORD == {4'h8, $past(TEMP_DATA)})
		else $error("temperature word wrong");

	chk_rsp_pulse: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!RDBK_REQ && !ADC_VALID && !TEMP_VALID && !sw_clr)
		|=> !RSP_VALID ##0 $stable(RSP_WORD))
		else $error("answer without a source");

	// a keyed word is the only cause of the reset pulse
	chk_srst_cause: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!(CMD_VALID && CMD_WORD == 16'h7DAC) |=> !SOFT_RST)
		else $error("reset pulse without a keyed word");

	// readback wins over conversion and temperature; only a keyed reset word beats it
	chk_rdbk_first: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(RDBK_REQ && !sw_clr)
		|=> RSP_VALID && RSP_WORD[15] && RSP_WORD[14:12] == $past(RDBK_CHAN))
		else $error("readback lost to another source");

endmodule

/* verification/host_model.sv */
// host side model that hands command words to the decoder
`include "io_word_consts.svh"
module host_model (
	input wire logic clk,
	output logic cmd_valid,
	output logic [15:0] cmd_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idle at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
	end
	// one word held across exactly one taking edge
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd_word = w;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		cmd_word = ~w; // stale word must not look valid
	endtask
	// three-state word, reserved bits kept zero
	task automatic ts(input logic [7:0] pins);
		send({1'b0, `TS_REG_ADDR, 3'h0, pins});
	endtask
	// reset word with the given key
	task automatic rst(input logic [10:0] key);
		send({1'b0, `RST_REG_ADDR, key});
	endtask
	// converter data write
	task automatic dac(input logic [2:0] ch, input logic [11:0] code);
		send({1'b1, ch, code});
	endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench of the command word decoder
`include "io_word_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// signals
	// ****************
	logic core_clk, nrst, cmd_valid, adc_valid, temp_valid, rdbk_req, rsp_valid, soft_rst;
	logic [15:0] cmd_word, rsp_word;
	logic [2:0] adc_chan, rdbk_chan;
	logic [11:0] adc_data, temp_data;
	logic [7:0] pin_float;
	logic [95:0] dac_codes;
	int bad_count, comparisons;
	host_model host (.clk(core_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
	io_word_decode dut (.CORE_CLK(core_clk), .NRST(nrst), .CMD_VALID(cmd_valid),
		.CMD_WORD(cmd_word), .ADC_VALID(adc_valid), .ADC_CHAN(adc_chan),
		.ADC_DATA(adc_data), .TEMP_VALID(temp_valid), .TEMP_DATA(temp_data),
		.RDBK_REQ(rdbk_req), .RDBK_CHAN(rdbk_chan), .PIN_FLOAT(pin_float),
		.DAC_CODES(dac_codes), .RSP_VALID(rsp_valid), .RSP_WORD(rsp_word),
		.SOFT_RST(soft_rst));
	// ****************
	// helpers
	// ****************
	task automatic chk(input string n, input logic [95:0] seen, input logic [95:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// one answer request; kind is {readback, conversion, temperature}
	task automatic ask(input logic [2:0] kind, input logic [2:0] ch, input logic [11:0] d,
		input logic [15:0] exp);
		@(posedge core_clk);
		#1 {rdbk_req, adc_valid, temp_valid} = kind;
		rdbk_chan = ch;
		adc_chan = ch;
		adc_data = d;
		temp_data = d;
		@(posedge core_clk);
		#1 {rdbk_req, adc_valid, temp_valid} = 3'h0;
		adc_data = ~d; // released data never repeats the last value
		chk("rsp_valid", rsp_valid, 1'b1);
		chk("rsp_word", rsp_word, exp);
		@(posedge core_clk);
		#1 chk("rsp_pulse", rsp_valid, 1'b0);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_float;
		chk("float_reset", pin_float, `TS_RESET);
		host.ts(8'hA5);
		chk("float_a5", pin_float, 8'hA5);
		host.send({1'b0, 4'hC, 11'h0FF});
		chk("float_other_addr", pin_float, 8'hA5);
		$display("t_float done");
	endtask
	task automatic t_dac;
		for (int c = 0; c < 8; c++) begin
			host.dac(c[2:0], {c[2:0], 9'h155});
			chk("code", dac_codes[12*c +: 12], {c[2:0], 9'h155});
		end
		for (int c = 0; c < 8; c++) begin
			ask(3'b100, c[2:0], 12'h000, {1'b1, c[2:0], c[2:0], 9'h155});
		end
		$display("t_dac done");
	endtask
	task automatic t_answers;
		ask(3'b010, 3'h5, 12'hABC, {1'b0, 3'h5, 12'hABC});
		ask(3'b001, 3'h2, 12'h7FE, {`TEMP_TAG, 12'h7FE});
		ask(3'b011, 3'h7, 12'hFFF, {1'b0, 3'h7, 12'hFFF});
		ask(3'b110, 3'h1, 12'h000, {1'b1, 3'h1, 12'h355});
		$display("t_answers done");
	endtask
	// readback in the write's own cycle sees the old code, one cycle later the new one
	task automatic t_race;
		fork
			host.dac(3'h4, 12'h123);
			ask(3'b100, 3'h4, 12'h000, {1'b1, 3'h4, 12'h955});
		join
		fork
			host.dac(3'h3, 12'h9C3);
			begin
				@(posedge core_clk);
				ask(3'b100, 3'h3, 12'h000, {1'b1, 3'h3, 12'h9C3});
			end
		join
		chk("race_code", dac_codes[47:36], 12'h9C3);
		$display("t_race done");
	endtask
	task automatic t_soft;
		host.rst(11'h5AD);
		chk("bad_key_pulse", soft_rst, 1'b0);
		chk("bad_key_float", pin_float, 8'hA5);
		chk("bad_key_code", dac_codes[95:84], 12'hF55);
		host.rst(`RST_KEY);
		chk("key_pulse", soft_rst, 1'b1);
		chk("key_float", pin_float, `TS_RESET);
		chk("key_codes", dac_codes, 96'h0);
		chk("key_word", rsp_word, `WORD_RESET);
		chk("key_rsp_valid", rsp_valid, 1'b0);
		@(posedge core_clk);
		#1 chk("key_pulse_end", soft_rst, 1'b0);
		$display("t_soft done");
	endtask
	// ****************
	// clock, main sequence, watchdog
	// ****************
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		{nrst, adc_valid, temp_valid, rdbk_req} = 4'h0;
		{adc_chan, rdbk_chan, adc_data, temp_data} = 30'h0;
		bad_count = 0;
		comparisons = 0;
		repeat (4) @(posedge core_clk);
		#1 nrst = 1'b1;
		t_float();
		t_dac();
		t_answers();
		t_race();
		t_soft();
		print_verdict();
	end
	// whole run needs under 200 cycles
	initial begin
		#(2000 * 100);
		bad_count++;
		print_verdict();
	end
endmodule
